/* hdl/oatr_defs.vh */
// constants for the oscillator and amplifier trim register bank
`ifndef OATR_DEFS_VH
`define OATR_DEFS_VH

// register word indices; byte address is four times the index
`define OATR_IDX_CAP_COARSE 8'h62
`define OATR_IDX_CAP_FINE 8'h63
`define OATR_IDX_SPARE 8'h64
`define OATR_IDX_OSC_START 8'h65
`define OATR_IDX_LEVEL_OFS 8'h66
`define OATR_IDX_AMP_RANGE 8'h67
`define OATR_IDX_AMP_FINE 8'h68
`define OATR_IDX_OSC_STATUS 8'h69

// reset values
`define OATR_RST_CAP_COARSE 8'h88
`define OATR_RST_CAP_FINE 8'h80
`define OATR_RST_SPARE 8'h00
`define OATR_RST_OSC_START 8'h0F
`define OATR_RST_LEVEL_OFS 8'h28
`define OATR_RST_AMP_RANGE 8'h13
`define OATR_RST_AMP_FINE 8'h10
`define OATR_RST_SUPPLY_COARSE 4'h3
`define OATR_RST_SUPPLY_FINE 6'h10

// field positions
`define OATR_BIT_START_SEL 5
`define OATR_BIT_OFS_SIGN 7
`define OATR_OFS_MSB 5
`define OATR_BIT_RAMP 6
`define OATR_RANGE_MSB 5
`define OATR_RANGE_LSB 4
`define OATR_SUPPLY_MSB 3
`define OATR_FINE_MSB 5
`define OATR_COARSE_OUT_MSB 7
`define OATR_COARSE_OUT_LSB 4
`define OATR_COARSE_IN_MSB 3

// power range codes
`define OATR_RANGE_0DBM 2'h0
`define OATR_RANGE_10DBM 2'h1
`define OATR_RANGE_13DBM 2'h2
`define OATR_RANGE_20DBM 2'h2
`define OATR_RANGE_BAD 2'h3

// signal-level arithmetic width
`define OATR_LEVEL_W 8

// oscillator settle qualification, in system clocks
`define OATR_SETTLE_CYC 4'h4

`endif

/* hdl/oatr_sync2.v */
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module oatr_sync2 (
	input wire sys_clk,
	input wire rst_n,
	input wire d_in,
	output wire q_out
);
	reg meta_q;
	reg sync_q;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end
	assign q_out = sync_q;
endmodule // oatr_sync2
`default_nettype wire

/* hdl/oatr_level_adj.v */
// signed offset applied to a measured signal level, saturating
`timescale 1ns/1ps
`default_nettype none
`include "oatr_defs.vh"
module oatr_level_adj (
	input wire [`OATR_LEVEL_W-1:0] level_in,
	input wire add_sel,
	input wire [`OATR_OFS_MSB:0] offset,
	output reg [`OATR_LEVEL_W-1:0] level_out
);
	reg [`OATR_LEVEL_W:0] sum;
	always @* begin
		sum = {1'b0, level_in};
		if (add_sel) begin // R5
			sum = {1'b0, level_in} + {3'h0, offset}; // R6
			level_out = sum[`OATR_LEVEL_W] ? 8'hFF : sum[`OATR_LEVEL_W-1:0];
		end else begin
			sum = {1'b0, level_in} - {3'h0, offset}; // R6
			level_out = sum[`OATR_LEVEL_W] ? 8'h00 : sum[`OATR_LEVEL_W-1:0];
		end
	end
endmodule // oatr_level_adj
`default_nettype wire

/* hdl/oatr_regs.v */
// oscillator and amplifier trim register bank with wishbone slave
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oatr_defs.vh"
// Functional notes
// R1 - software keeps fine trim within 0x00 to 0x77
// R2 - start bit clear: fast start, trims zero
// R3 - start bit set: programmed trims from start
// R4 - fast start swaps in programmed trims once stable
// R5 - sign bit: clear subtracts, set adds offset
// R6 - six-bit offset magnitude, reset 0x28
// R7 - ramp bit picks legacy or high-power scheme
// R8 - legacy range codes 0/10/13 dBm, 11 forbidden
// R9 - high-power variant only uses range code 10
// R10 - four-bit coarse supply trim, reset 0011
// R11 - six-bit fine supply trim, reset 010000
// R12 - spare register read/write, resets zero
// R13 - two coarse pin trims, each reset 1000
// R14 - registers read back last write, next edge
module oatr_regs (
	input wire sys_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [9:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	input wire osc_run,
	input wire osc_stable,
	input wire [7:0] level_raw,
	output reg [7:0] level_adjusted_q,
	output reg [3:0] out_pin_cap_coarse_q,
	output reg [3:0] in_pin_cap_coarse_q,
	output reg [7:0] load_cap_fine_q,
	output reg amp_ramp_style_q,
	output reg [1:0] amp_power_range_q,
	output reg amp_range_fault_q,
	output reg [3:0] amp_supply_coarse_q,
	output reg [5:0] amp_supply_fine_q
);
	localparam ST_OFF = 4'h1;
	localparam ST_FAST = 4'h2;
	localparam ST_SETTLE = 4'h4;
	localparam ST_TRIMMED = 4'h8;

	reg [7:0] cap_coarse_q;
	reg [7:0] cap_fine_q;
	reg [7:0] spare_q;
	reg [7:0] osc_start_q;
	reg [7:0] level_ofs_q;
	reg [7:0] amp_range_q;
	reg [7:0] amp_fine_q;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [3:0] settle_q;
	reg [3:0] settle_d;
	reg [7:0] rd_data;
	reg hit;
	wire run_s;
	wire stable_s;
	wire [7:0] level_s;
	wire [7:0] level_adj;
	wire [7:0] idx;
	wire req;
	wire wr_en;
	wire trims_zero;
	wire wr_cap_coarse;
	wire wr_cap_fine;
	wire wr_spare;
	wire wr_osc_start;
	wire wr_level_ofs;
	wire wr_amp_range;
	wire wr_amp_fine;
	reg [7:0] level_prev_q;
	reg [7:0] level_hold_q;

	// pins from the analog oscillator pass two flops first
	oatr_sync2 u_sync_run (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.d_in(osc_run),
		.q_out(run_s)
	);
	oatr_sync2 u_sync_stable (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.d_in(osc_stable),
		.q_out(stable_s)
	);
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_lvl
			// per-bit sync; a changing multi-bit level may tear for one sample
			oatr_sync2 u_sync_lvl (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.d_in(level_raw[gi]),
				.q_out(level_s[gi])
			);
		end
	endgenerate

	// a sample is used only once two in a row agree, so a torn word never reaches the adder;
	// the price is that a level changing on every clock keeps its last steady value
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_prev_q <= 8'h00;
			level_hold_q <= 8'h00;
		end else begin
			level_prev_q <= level_s;
			if (level_s == level_prev_q) begin
				level_hold_q <= level_s;
			end
		end
	end

	oatr_level_adj u_level (
		.level_in(level_hold_q),
		.add_sel(level_ofs_q[`OATR_BIT_OFS_SIGN]), // R5
		.offset(level_ofs_q[`OATR_OFS_MSB:0]), // R6
		.level_out(level_adj)
	);

	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr_en = req & wb_we_i & wb_sel_i[0] & hit;

	always @* begin
		hit = 1'b1;
		rd_data = 8'h00;
		case (idx)
			`OATR_IDX_CAP_COARSE: rd_data = cap_coarse_q;
			`OATR_IDX_CAP_FINE: rd_data = cap_fine_q;
			`OATR_IDX_SPARE: rd_data = spare_q;
			`OATR_IDX_OSC_START: rd_data = osc_start_q;
			`OATR_IDX_LEVEL_OFS: rd_data = level_ofs_q;
			`OATR_IDX_AMP_RANGE: rd_data = amp_range_q;
			`OATR_IDX_AMP_FINE: rd_data = amp_fine_q;
			`OATR_IDX_OSC_STATUS: rd_data = {4'h0, state_q};
			default: hit = 1'b0;
		endcase
	end

	// bus answer: ack or err one cycle after the request, dropped the next
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= req & hit; // R14
			wb_err_o <= req & ~hit;
		end
	end

	// read data stays put between reads so a late sampler still sees it
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (req & hit & ~wb_we_i) begin // R14
			wb_dat_o <= {24'h000000, rd_data};
		end
	end

	// register file; all bits including reserved ones read back as written
	assign wr_cap_coarse = wr_en & (idx == `OATR_IDX_CAP_COARSE);
	assign wr_cap_fine = wr_en & (idx == `OATR_IDX_CAP_FINE);
	assign wr_spare = wr_en & (idx == `OATR_IDX_SPARE);
	assign wr_osc_start = wr_en & (idx == `OATR_IDX_OSC_START);
	assign wr_level_ofs = wr_en & (idx == `OATR_IDX_LEVEL_OFS);
	assign wr_amp_range = wr_en & (idx == `OATR_IDX_AMP_RANGE);
	assign wr_amp_fine = wr_en & (idx == `OATR_IDX_AMP_FINE);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_coarse_q <= `OATR_RST_CAP_COARSE; // R13
		end else if (wr_cap_coarse) begin // R14
			cap_coarse_q <= wb_dat_i[7:0]; // R13
		end
	end

	// no clamp: staying at or below 0x77 is software's job
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_fine_q <= `OATR_RST_CAP_FINE;
		end else if (wr_cap_fine) begin // R14
			cap_fine_q <= wb_dat_i[7:0]; // R1
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			spare_q <= `OATR_RST_SPARE; // R12
		end else if (wr_spare) begin // R14
			spare_q <= wb_dat_i[7:0]; // R12
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_start_q <= `OATR_RST_OSC_START;
		end else if (wr_osc_start) begin // R14
			osc_start_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_ofs_q <= `OATR_RST_LEVEL_OFS; // R6
		end else if (wr_level_ofs) begin // R14
			level_ofs_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_range_q <= `OATR_RST_AMP_RANGE;
		end else if (wr_amp_range) begin // R14
			amp_range_q <= wb_dat_i[7:0];
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_fine_q <= `OATR_RST_AMP_FINE; // R11
		end else if (wr_amp_fine) begin // R14
			amp_fine_q <= wb_dat_i[7:0];
		end
	end

	// oscillator start sequencing
	always @* begin
		state_d = state_q;
		settle_d = settle_q;
		case (state_q)
			ST_OFF: begin
				// start bit is read only here; a later write waits for the next start
				if (run_s) begin
					if (osc_start_q[`OATR_BIT_START_SEL]) begin
						state_d = ST_TRIMMED; // R3
					end else begin
						state_d = ST_FAST; // R2
					end
				end
			end
			ST_FAST: begin
				settle_d = 4'h0;
				if (!run_s) begin
					state_d = ST_OFF;
				end else if (stable_s) begin
					state_d = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				// a few clocks of steady stable filter a glitchy indicator
				if (!run_s || !stable_s) begin
					state_d = run_s ? ST_FAST : ST_OFF;
				end else if (settle_q == `OATR_SETTLE_CYC - 4'h1) begin
					state_d = ST_TRIMMED; // R4
				end else begin
					settle_d = settle_q + 4'h1;
				end
			end
			ST_TRIMMED: begin
				if (!run_s) begin
					state_d = ST_OFF;
				end
			end
			default: state_d = ST_OFF;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_q <= 4'h0;
		end else begin
			settle_q <= settle_d;
		end
	end

	// trims are held at zero until the trimmed state is reached
	assign trims_zero = (state_q != ST_TRIMMED);

	// analog-facing outputs, all registered
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_pin_cap_coarse_q <= 4'h0;
			in_pin_cap_coarse_q <= 4'h0;
			load_cap_fine_q <= 8'h00;
		end else if (trims_zero) begin // R2
			out_pin_cap_coarse_q <= 4'h0;
			in_pin_cap_coarse_q <= 4'h0;
			load_cap_fine_q <= 8'h00;
		end else begin // R3 R4
			out_pin_cap_coarse_q <= cap_coarse_q[`OATR_COARSE_OUT_MSB:`OATR_COARSE_OUT_LSB]; // R13
			in_pin_cap_coarse_q <= cap_coarse_q[`OATR_COARSE_IN_MSB:0]; // R13
			load_cap_fine_q <= cap_fine_q;
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_adjusted_q <= 8'h00;
		end else begin
			level_adjusted_q <= level_adj; // R5
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_ramp_style_q <= 1'b0;
			amp_power_range_q <= `OATR_RANGE_10DBM;
			amp_supply_coarse_q <= `OATR_RST_SUPPLY_COARSE;
			amp_supply_fine_q <= `OATR_RST_SUPPLY_FINE;
		end else begin
			amp_ramp_style_q <= amp_range_q[`OATR_BIT_RAMP]; // R7
			amp_power_range_q <= amp_range_q[`OATR_RANGE_MSB:`OATR_RANGE_LSB]; // R8
			amp_supply_coarse_q <= amp_range_q[`OATR_SUPPLY_MSB:0]; // R10
			amp_supply_fine_q <= amp_fine_q[`OATR_FINE_MSB:0]; // R11
		end
	end

	// flags a code that the selected ramp style forbids; informative only, nothing is blocked
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			amp_range_fault_q <= 1'b0;
		end else if (amp_range_q[`OATR_BIT_RAMP]) begin
			amp_range_fault_q <= (amp_range_q[`OATR_RANGE_MSB:`OATR_RANGE_LSB] != `OATR_RANGE_20DBM); // R9
		end else begin
			amp_range_fault_q <= (amp_range_q[`OATR_RANGE_MSB:`OATR_RANGE_LSB] == `OATR_RANGE_BAD); // R8
		end
	end
endmodule // oatr_regs
`default_nettype wire

/* verif/oatr_regs_sva.sv */
// port assertions for the trim register bank
`timescale 1ns/1ps
`default_nettype none
module oatr_regs_sva (
	input wire sys_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [9:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire amp_ramp_style_q,
	input wire amp_range_fault_q,
	input wire [1:0] amp_power_range_q,
	input wire [3:0] amp_supply_coarse_q,
	input wire [5:0] amp_supply_fine_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire take = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
	wire mapped = wb_adr_i[9:2] >= 8'h62 && wb_adr_i[9:2] <= 8'h69;
	wire wr_en = take & wb_we_i & wb_sel_i[0];
	sequence wr_amp; wr_en && wb_adr_i[9:2] == 8'h67; endsequence
	sequence wr_fine; wr_en && wb_adr_i[9:2] == 8'h68; endsequence
	sequence wr_amp_hp; wr_en && wb_adr_i[9:2] == 8'h67 && wb_dat_i[6]; endsequence
	sequence wr_amp_lg; wr_en && wb_adr_i[9:2] == 8'h67 && !wb_dat_i[6]; endsequence
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_timing_a: assert property (take && mapped |=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acked");
	err_unmapped_a: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	ramp_follow_a: assert property (wr_amp |=> ##1 amp_ramp_style_q == $past(wb_dat_i[6], 2))
		else $error("ramp style not applied");
	range_follow_a: assert property (wr_amp |=> ##1 amp_power_range_q == $past(wb_dat_i[5:4], 2))
		else $error("power range not applied");
	coarse_follow_a: assert property (wr_amp |=> ##1 amp_supply_coarse_q == $past(wb_dat_i[3:0], 2))
		else $error("coarse supply not applied");
	fine_follow_a: assert property (wr_fine |=> ##1 amp_supply_fine_q == $past(wb_dat_i[5:0], 2))
		else $error("fine supply not applied");
	fault_hp_a: assert property (wr_amp_hp |=> ##1 amp_range_fault_q == ($past(wb_dat_i[5:4], 2) != 2'h2))
		else $error("high-power range fault wrong");
	fault_legacy_a: assert property (wr_amp_lg |=> ##1 amp_range_fault_q == ($past(wb_dat_i[5:4], 2) == 2'h3))
		else $error("legacy range fault wrong");
endmodule // oatr_regs_sva
bind oatr_regs oatr_regs_sva oatr_regs_sva_inst (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .amp_ramp_style_q, .amp_power_range_q,
	.amp_range_fault_q, .amp_supply_coarse_q, .amp_supply_fine_q);
`default_nettype wire

/* verif/test_osc_and_amp_trim_regs.sv */
// self-checking bench for the trim register bank
`timescale 1ns/1ps
`default_nettype none
module test_osc_and_amp_trim_regs;
	logic sys_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, run = 0, stab = 0, ack, err, ramp, flt, es;
	logic [9:0] adr = 0;
	logic [3:0] sel = 0, co, ci, sc;
	logic [31:0] di = 0, dout, rv;
	logic [7:0] raw = 0, lvl, fine;
	logic [1:0] rng;
	logic [5:0] sf;
	logic [7:0] rst_tab [8] = '{8'h88, 8'h80, 8'h00, 8'h0F, 8'h28, 8'h13, 8'h10, 8'h01};
	logic [7:0] wv [7] = '{8'hF0, 8'h77, 8'hFF, 8'hDF, 8'hC1, 8'hAE, 8'hFF};
	int n_fail = 0, total_checks = 0, cyc_n = 0;
	always #12.5 sys_clk = ~sys_clk;
	oatr_regs oatr_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err),
		.osc_run(run), .osc_stable(stab), .level_raw(raw), .level_adjusted_q(lvl), .out_pin_cap_coarse_q(co),
		.in_pin_cap_coarse_q(ci), .load_cap_fine_q(fine), .amp_ramp_style_q(ramp), .amp_power_range_q(rng),
		.amp_range_fault_q(flt), .amp_supply_coarse_q(sc), .amp_supply_fine_q(sf));
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until ack or err is sampled, then released for a cycle
	task bus(input logic [7:0] i, input logic w, input logic [7:0] d, input logic s);
		@(posedge sys_clk);
		cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= {i, 2'h0}; sel <= {3'h0, s}; di <= {24'h0, d};
		do @(posedge sys_clk); while (ack !== 1'h1 && err !== 1'h1);
		rv = dout;
		es = err;
		cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
	endtask
	task rd(input logic [7:0] i, input logic [7:0] e);
		bus(i, 1'h0, 8'h00, 1'h1);
		chk(rv, {24'h0, e});
	endtask
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cyc_n++;
		if (cyc_n > 5000) begin
			n_fail++;
			end_of_test;
		end
	end
	initial begin
		wt(8);
		rst_n <= 1'h1;
		for (int k = 0; k < 8; k++) rd(8'h62 + k[7:0], rst_tab[k]);
		chk({ramp, rng, sc, sf, flt}, {1'h0, 2'h1, 4'h3, 6'h10, 1'h0});
		chk({co, ci, fine, lvl}, 24'h000000);
		$display("reset values done");
		for (int k = 0; k < 7; k++) bus(8'h62 + k[7:0], 1'h1, wv[k], 1'h1);
		for (int k = 0; k < 7; k++) rd(8'h62 + k[7:0], wv[k]);
		wt(1);
		chk({ramp, rng, sc, sf}, {1'h0, 2'h2, 4'hE, 6'h3F});
		bus(8'h69, 1'h1, 8'hFF, 1'h1);
		rd(8'h69, 8'h01);
		bus(8'h63, 1'h1, 8'h11, 1'h0);
		rd(8'h63, 8'h77);
		bus(8'h70, 1'h0, 8'h00, 1'h1);
		chk(es, 1'h1);
		$display("access done");
		// forbidden codes written on purpose to see the fault flag
		for (int k = 0; k < 8; k++) begin
			bus(8'h67, 1'h1, {1'h0, k[2], k[1:0], 4'h3}, 1'h1);
			wt(1);
			chk({ramp, rng, flt}, {k[2], k[1:0], k[2] ? k[1:0] != 2'h2 : k[1:0] == 2'h3});
		end
		$display("range fault done");
		raw <= 8'h50;
		bus(8'h66, 1'h1, 8'h05, 1'h1);
		wt(6);
		chk(lvl, 8'h4B);
		bus(8'h66, 1'h1, 8'h85, 1'h1);
		wt(6);
		chk(lvl, 8'h55);
		raw <= 8'hF0;
		bus(8'h66, 1'h1, 8'hBF, 1'h1);
		wt(6);
		chk(lvl, 8'hFF);
		raw <= 8'h02;
		bus(8'h66, 1'h1, 8'h28, 1'h1);
		wt(6);
		chk(lvl, 8'h00);
		$display("level done");
		bus(8'h62, 1'h1, 8'h5C, 1'h1);
		bus(8'h63, 1'h1, 8'h33, 1'h1);
		bus(8'h65, 1'h1, 8'h00, 1'h1);
		run <= 1'h1;
		wt(8);
		chk({co, ci, fine}, 16'h0000);
		rd(8'h69, 8'h02);
		stab <= 1'h1;
		wt(14);
		chk({co, ci, fine}, 16'h5C33);
		run <= 1'h0;
		stab <= 1'h0;
		bus(8'h65, 1'h1, 8'h20, 1'h1);
		wt(8);
		chk({co, ci, fine}, 16'h0000);
		run <= 1'h1;
		wt(8);
		chk({co, ci, fine}, 16'h5C33);
		$display("oscillator done");
		end_of_test;
	end
endmodule // test_osc_and_amp_trim_regs
`default_nettype wire
